// ===== src/crc_defs.svh
// Constants of the programmable CRC engine: register indices, field positions,
// reset values and FIFO depths. Included by every design file that needs them.
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// ************************************************************
// Register indices on the special-function-register port
// ************************************************************
`define CRC_REG_CTRL       2'h0
`define CRC_REG_TAP        2'h1
`define CRC_REG_FIFO       2'h2
`define CRC_REG_SHIFT      2'h3

// ************************************************************
// Control/status register fields
// ************************************************************
`define CRC_CTRL_PLEN_LSB  0
`define CRC_CTRL_PLEN_MSB  3
`define CRC_CTRL_GO_BIT    4
`define CRC_CTRL_EMPTY_BIT 6
`define CRC_CTRL_FULL_BIT  7
`define CRC_CTRL_CNT_LSB   8
`define CRC_CTRL_CNT_MSB   12

// ************************************************************
// Reset values and FIFO geometry
// ************************************************************
`define CRC_CTRL_RST       16'h0040
`define CRC_TAP_RST        16'h0000
`define CRC_SHIFT_RST      16'h0000
`define CRC_PLEN_BYTE_MAX  4'h7
`define CRC_WORD_DEPTH     5'h08
`define CRC_BYTE_DEPTH     5'h10

`endif

// ===== src/crc_pkg.sv
// Types shared by the CRC engine modules: shifter states and state records.
// Assumes the fixed geometry of a 16-byte FIFO and a 16-bit shift register.
package crc_pkg;

  // Serial shifter states
  typedef enum logic {CRC_IDLE, CRC_SHIFT} crc_shift_e;

  // Byte storage of the FIFO with its byte pointers
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0]       wp;
    logic [3:0]       rp;
  } crc_fifo_s;

  // Shift register of the calculator
  typedef struct packed {
    logic [15:0] sr;
  } crc_shreg_s;

  // Control state of the top level
  typedef struct packed {
    crc_shift_e  state;
    logic [3:0]  bit_idx;
    logic [4:0]  count;
    logic        half;
    logic        go;
    logic [3:0]  plen;
    logic [15:1] taps;
    logic [15:0] rdata;
    logic        done;
  } crc_top_s;

endpackage : crc_pkg

// ===== src/crc_fifo.sv
// Byte-organised FIFO storage: one or two bytes pushed, one or two popped.
// Assumes the caller keeps the element count; no overflow protection here.
module crc_fifo
  import crc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        clk_en,
  input  wire logic        rst_n,
  // Fill side
  input  wire logic        push,
  input  wire logic        push_word,
  input  wire logic [15:0] push_data,
  input  wire logic        flush,
  // Drain side
  input  wire logic        pop,
  input  wire logic        pop_word,
  output logic      [15:0] head
);

  crc_fifo_s st_ff;
  crc_fifo_s nxt_st;
  logic [3:0] wa;

  // Pointer update and storage write; a flush restarts at location zero
  always_comb
  begin
    nxt_st = st_ff;
    wa     = flush ? 4'h0 : st_ff.wp;
    if (flush)
    begin
      nxt_st.rp = 4'h0;
    end
    else if (pop)
    begin
      nxt_st.rp = st_ff.rp + (pop_word ? 4'h2 : 4'h1);
    end
    if (push)
    begin
      nxt_st.mem[wa] = push_data[7:0];
      if (push_word)
      begin
        nxt_st.mem[wa + 4'h1] = push_data[15:8];
      end
      nxt_st.wp = wa + (push_word ? 4'h2 : 4'h1);
    end
    else if (flush)
    begin
      nxt_st.wp = 4'h0;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  // Oldest element; in word mode the later byte is the upper half
  assign head = pop_word ? {st_ff.mem[st_ff.rp + 4'h1], st_ff.mem[st_ff.rp]}
                         : {8'h00, st_ff.mem[st_ff.rp]};

endmodule : crc_fifo

// ===== src/crc_shreg.sv
// XOR feedback shift register, MSb-first, programmable length and taps.
// Assumes load and step are never needed in the same cycle; load wins.
module crc_shreg
  import crc_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 clk_en,
  input  wire logic                 rst_n,
  // Direct load
  input  wire logic                 load,
  input  wire logic [W-1:0]         load_data,
  // Serial step
  input  wire logic                 step,
  input  wire logic                 din,
  input  wire logic [$clog2(W)-1:0] msb_sel,
  input  wire logic [W-1:1]         taps,
  output logic      [W-1:0]         sr
);

  logic [W-1:0] st_ff;
  logic [W-1:0] nxt_st;
  logic         fb;

  // One shift: feedback from the selected top tap, x^0 always applied
  always_comb
  begin
    nxt_st = st_ff;
    fb     = din ^ st_ff[msb_sel];
    if (load)
    begin
      nxt_st = load_data;
    end
    else if (step)
    begin
      nxt_st[0] = fb;
      for (int k = 1; k < W; k++)
      begin
        nxt_st[k] = (k <= int'(msb_sel)) ? (st_ff[k-1] ^ (fb & taps[k])) : 1'b0;
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign sr = st_ff;

endmodule : crc_shreg

// ===== src/crc_engine.sv
// Programmable CRC engine: register port, FIFO fill control and serial shifter.
// Assumes a CPU on the same clock drives the register port; one bit per clock
// is shifted, the clock running at twice the instruction rate.
`include "crc_defs.svh"

module crc_engine
  import crc_pkg::*;
(
  // Clock, enable and reset
  input  wire logic        clk,
  input  wire logic        clk_en,
  input  wire logic        rst_n,
  // Special-function-register port
  input  wire logic [1:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [1:0]  sfr_be,
  input  wire logic [15:0] sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [15:0] sfr_rdata,
  // Event toward the interrupt controller
  output logic             crc_done_pulse
);

  // ************************************************************
  // Declarations
  // ************************************************************
  crc_top_s    st_ff;
  crc_top_s    nxt_st;
  logic        byte_mode;
  logic        word_wr;
  logic        fifo_wr;
  logic        fifo_full_flag;
  logic        fifo_empty_flag;
  logic        overflow;
  logic [4:0]  inc;
  logic        pop;
  logic        step;
  logic        sr_load;
  logic [15:0] sr_load_data;
  logic [15:0] push_data;
  logic [15:0] head;
  logic [15:0] sr;
  logic [4:0]  depth;

  // Reset images of the control and tap registers, sliced per field in the reset branch
  localparam logic [15:0] CTRL_RST = `CRC_CTRL_RST;
  localparam logic [15:0] TAP_RST  = `CRC_TAP_RST;

  // ************************************************************
  // Write decode and FIFO accounting
  // ************************************************************
  // mode select
  assign byte_mode       = (st_ff.plen <= `CRC_PLEN_BYTE_MAX);
  assign word_wr         = (sfr_be == 2'b11);
  assign fifo_wr         = sfr_wr && (sfr_addr == `CRC_REG_FIFO) && (sfr_be != 2'b00);
  assign depth           = byte_mode ? `CRC_BYTE_DEPTH : `CRC_WORD_DEPTH;
  assign fifo_full_flag  = (st_ff.count == depth);
  assign fifo_empty_flag = (st_ff.count == 5'h00);
  assign overflow        = fifo_wr && fifo_full_flag;

  // increment per write; a lone byte in word mode waits for its pair
  always_comb
  begin
    if (!fifo_wr)
      inc = 5'h00;
    else if (byte_mode)
      inc = word_wr ? 5'h02 : 5'h01;
    else
      inc = (word_wr || st_ff.half) ? 5'h01 : 5'h00;
  end

  // Single byte writes take the enabled lane into the low byte
  assign push_data = word_wr ? sfr_wdata
                             : {8'h00, (sfr_be == 2'b10) ? sfr_wdata[15:8] : sfr_wdata[7:0]};

  // ************************************************************
  // Serial shifter control
  // ************************************************************
  // pop after the last bit; a flush aborts the element in flight
  assign pop     = (st_ff.state == CRC_SHIFT) && (st_ff.bit_idx == 4'h0) && !overflow;
  // one bit per clock while shifting
  assign step    = (st_ff.state == CRC_SHIFT) && !overflow;
  // direct load merges the written byte lanes
  assign sr_load = sfr_wr && (sfr_addr == `CRC_REG_SHIFT);
  assign sr_load_data = {sfr_be[1] ? sfr_wdata[15:8] : sr[15:8],
                         sfr_be[0] ? sfr_wdata[7:0]  : sr[7:0]};

  // Next state of counter, shifter, registers and read data
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;

    // wrap through zero and keep only the new data
    if (overflow)
      nxt_st.count = inc;
    else
      nxt_st.count = st_ff.count + inc - (pop ? 5'h01 : 5'h00);

    // byte pairing in word mode only
    if (fifo_wr && !word_wr && !byte_mode)
      nxt_st.half = !st_ff.half;
    else if (byte_mode || overflow)
      nxt_st.half = 1'b0;

    unique case (st_ff.state)
      CRC_IDLE:
      begin
        if (st_ff.go && (st_ff.count != 5'h00) && !overflow)
        begin
          nxt_st.state   = CRC_SHIFT;
          nxt_st.bit_idx = st_ff.plen;
        end
      end
      CRC_SHIFT:
      begin
        if (overflow)
          nxt_st.state = CRC_IDLE;
        else if (st_ff.bit_idx == 4'h0)
        begin
          // run on regardless of go until the count is zero
          if (nxt_st.count == 5'h00)
            nxt_st.state = CRC_IDLE;
          // next element starts at its length-field bit
          nxt_st.bit_idx = st_ff.plen;
          // completion when the count falls to zero
          nxt_st.done    = (nxt_st.count == 5'h00);
        end
        else
          nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
      end
    endcase

    // Control register: go and length live in the low byte
    if (sfr_wr && (sfr_addr == `CRC_REG_CTRL) && sfr_be[0])
    begin
      nxt_st.go   = sfr_wdata[`CRC_CTRL_GO_BIT];
      nxt_st.plen = sfr_wdata[`CRC_CTRL_PLEN_MSB:`CRC_CTRL_PLEN_LSB];
    end

    // tap mask; bit 0 has no storage
    if (sfr_wr && (sfr_addr == `CRC_REG_TAP))
    begin
      if (sfr_be[1])
        nxt_st.taps[15:8] = sfr_wdata[15:8];
      if (sfr_be[0])
        nxt_st.taps[7:1] = sfr_wdata[7:1];
    end

    // Read data is registered: valid the cycle after the read strobe
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        `CRC_REG_CTRL:
        begin
          nxt_st.rdata = 16'h0000;
          nxt_st.rdata[`CRC_CTRL_CNT_MSB:`CRC_CTRL_CNT_LSB] = st_ff.count;
          nxt_st.rdata[`CRC_CTRL_FULL_BIT]  = fifo_full_flag;
          nxt_st.rdata[`CRC_CTRL_EMPTY_BIT] = fifo_empty_flag;
          nxt_st.rdata[`CRC_CTRL_GO_BIT]    = st_ff.go;
          nxt_st.rdata[`CRC_CTRL_PLEN_MSB:`CRC_CTRL_PLEN_LSB] = st_ff.plen;
        end
        `CRC_REG_TAP:   nxt_st.rdata = {st_ff.taps, 1'b0};
        `CRC_REG_FIFO:  nxt_st.rdata = 16'h0000;
        `CRC_REG_SHIFT: nxt_st.rdata = sr;
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Fields are cut from the reset images so no bit is dropped by width
      st_ff       <= '0;
      st_ff.state <= CRC_IDLE;
      st_ff.go    <= CTRL_RST[`CRC_CTRL_GO_BIT];
      st_ff.plen  <= CTRL_RST[`CRC_CTRL_PLEN_MSB:`CRC_CTRL_PLEN_LSB];
      st_ff.taps  <= TAP_RST[15:1];
    end
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign sfr_rdata      = st_ff.rdata;
  assign crc_done_pulse = st_ff.done & clk_en;

  // ************************************************************
  // Storage and calculator
  // ************************************************************
  // sixteen bytes serve as 8x16 or 16x8
  crc_fifo u_fifo
  (
    .clk       (clk),
    .clk_en    (clk_en),
    .rst_n     (rst_n),
    .push      (fifo_wr),
    .push_word (word_wr),
    .push_data (push_data),
    .flush     (overflow),
    .pop       (pop),
    .pop_word  (!byte_mode),
    .head      (head)
  );

  // the length field picks the feedback tap
  crc_shreg #(.W(16)) u_shreg
  (
    .clk       (clk),
    .clk_en    (clk_en),
    .rst_n     (rst_n),
    .load      (sr_load),
    .load_data (sr_load_data),
    .step      (step && !sr_load),
    .din       (head[st_ff.bit_idx]),
    .msb_sel   (st_ff.plen),
    .taps      (st_ff.taps),
    .sr        (sr)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Antecedents of the |=> checks carry clk_en: a frozen cycle repeats state and would
  // otherwise look like a missed step

  AST_FULL_DEPTH: assert property (
    clk_en && sfr_rd && sfr_addr == `CRC_REG_CTRL
    |=> sfr_rdata[`CRC_CTRL_FULL_BIT] == (sfr_rdata[`CRC_CTRL_CNT_MSB:`CRC_CTRL_CNT_LSB]
        == ((sfr_rdata[`CRC_CTRL_PLEN_MSB:`CRC_CTRL_PLEN_LSB] > `CRC_PLEN_BYTE_MAX)
            ? `CRC_WORD_DEPTH : `CRC_BYTE_DEPTH)))
    else $error("full flag does not match mode depth");

  AST_BYTE_INC: assert property (
    clk_en && byte_mode && fifo_wr && !word_wr && !fifo_full_flag && !pop
      && !(sfr_wr && sfr_addr == `CRC_REG_CTRL)
    |=> st_ff.count == $past(st_ff.count) + 5'h01)
    else $error("byte write did not add one in byte mode");

  AST_WORD_INC: assert property (
    clk_en && !byte_mode && fifo_wr && word_wr && !fifo_full_flag && !pop
    |=> st_ff.count == $past(st_ff.count) + 5'h01)
    else $error("word write did not add one in word mode");

  AST_OVERFLOW: assert property (
    clk_en && overflow |=> !st_ff.done && st_ff.count == $past(inc))
    else $error("write while full mishandled");

  AST_HOLD_IDLE: assert property (
    clk_en && st_ff.state == CRC_IDLE && !sr_load |=> $stable(sr))
    else $error("shift register moved while idle");

  AST_GO_CLEAR: assert property (
    clk_en && st_ff.state == CRC_SHIFT && !st_ff.go && st_ff.count > 5'h01 && !overflow
    |=> st_ff.state == CRC_SHIFT)
    else $error("clearing go halted shifting");

  AST_DONE_CAUSE: assert property (
    st_ff.done |-> fifo_empty_flag && $past(st_ff.count) == 5'h01)
    else $error("completion without count falling to zero");

  AST_ELEMENT_LEN: assert property (
    clk_en && st_ff.state == CRC_IDLE && st_ff.go && !fifo_empty_flag && !overflow
    |=> st_ff.bit_idx == $past(st_ff.plen))
    else $error("element did not start at length bit");

  AST_FIFO_READ_ZERO: assert property (
    clk_en && sfr_rd && sfr_addr == `CRC_REG_FIFO |=> sfr_rdata == 16'h0000)
    else $error("fifo port read not zero");

  AST_TAP_BIT0: assert property (
    clk_en && sfr_rd && sfr_addr == `CRC_REG_TAP |=> sfr_rdata[0] == 1'b0)
    else $error("tap bit 0 read nonzero");

  AST_IDLE_NO_GO: assert property (
    clk_en && st_ff.state == CRC_IDLE && !st_ff.go |=> st_ff.state == CRC_IDLE)
    else $error("shifter started without go");

  AST_STEP_DOWN: assert property (
    clk_en && st_ff.state == CRC_SHIFT && st_ff.bit_idx != 4'h0 && !overflow
    |=> st_ff.state == CRC_SHIFT && st_ff.bit_idx == $past(st_ff.bit_idx) - 4'h1)
    else $error("shifter did not take one bit per clock");

  AST_POP_DEC: assert property (
    clk_en && pop && !sfr_wr |=> st_ff.count == $past(st_ff.count) - 5'h01)
    else $error("finished element did not lower the count");

  AST_SHIFT_NONEMPTY: assert property (
    st_ff.state == CRC_SHIFT |-> !fifo_empty_flag)
    else $error("shifter running on an empty queue");

  AST_DONE_ONE: assert property (
    crc_done_pulse |=> !crc_done_pulse)
    else $error("completion event longer than one cycle");

  AST_SHIFT_LOAD: assert property (
    clk_en && sr_load |=> sr == $past(sr_load_data))
    else $error("direct load of the shift register lost");

  AST_OVF_IDLE: assert property (
    clk_en && overflow |=> st_ff.state == CRC_IDLE)
    else $error("element in flight not aborted by overflow");

  COV_OVERFLOW: cover property (clk_en && overflow);
  COV_DONE:     cover property (st_ff.done);
  COV_BYTE_FULL: cover property (byte_mode && fifo_full_flag);
  COV_MID_PUSH: cover property (clk_en && fifo_wr && st_ff.state == CRC_SHIFT);
  COV_PAIR:     cover property (clk_en && fifo_wr && !word_wr && !byte_mode && st_ff.half);

endmodule : crc_engine

// ===== dv/crc_cpu_model.sv
// CPU model on the special-function-register port of the CRC engine.
// Assumes the bench clock; every request changes just after a rising edge.
`include "crc_defs.svh"
module crc_cpu_model
(
  // Clock
  input  wire logic        clk,
  // Register port toward the engine
  output logic      [1:0]  sfr_addr,
  output logic             sfr_wr,
  output logic      [1:0]  sfr_be,
  output logic      [15:0] sfr_wdata,
  output logic             sfr_rd,
  input  wire logic [15:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    sfr_addr  = 2'h0;
    sfr_wr    = 1'b0;
    sfr_be    = 2'h0;
    sfr_wdata = 16'h0000;
    sfr_rd    = 1'b0;
  end

  // One write strobe held over exactly one taking edge
  task automatic wr(input logic [1:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_be    <= be;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d;
  endtask : wr

  // read waits a cycle
  // A read starts one edge after any write, so the count is settled
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask : rd

  // full checked first
  // The overflow flag lets a caller write into a full queue on purpose
  task automatic push(input logic [1:0] be, input logic [15:0] d, input bit ovf);
    logic [15:0] c;
    rd(`CRC_REG_CTRL, c);
    if (!c[`CRC_CTRL_FULL_BIT] || ovf)
      wr(`CRC_REG_FIFO, be, d);
  endtask : push

  task automatic load_shift(input logic [15:0] ctrl, input logic [15:0] v);
    wr(`CRC_REG_CTRL, 2'b11, ctrl & ~16'h0010);
    wr(`CRC_REG_SHIFT, 2'b11, v);
  endtask : load_shift
endmodule : crc_cpu_model

// ===== dv/crc_engine_tb_top.sv
// Self-checking bench of the CRC engine: queue reference model beside the
// CPU model. Assumes one 100 MHz clock; clk_en is dropped once to check the freeze.
`include "crc_defs.svh"
module crc_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [1:0]  sfr_addr;
  logic        sfr_wr;
  logic [1:0]  sfr_be;
  logic [15:0] sfr_wdata;
  logic        sfr_rd;
  logic [15:0] sfr_rdata;
  logic        crc_done_pulse;
  logic [15:0] rv;
  int          errors = 0;
  int          compares = 0;
  int          n_done = 0;
  int          exp_sr;
  int          plen;
  int          taps;
  int          d;
  int          q[$];
  time         t_go;
  time         t_done;

  crc_engine DUT (.clk(clk), .clk_en(clk_en), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_be(sfr_be), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .crc_done_pulse(crc_done_pulse));
  crc_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_be(sfr_be),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));

  // 10 ns clock
  always #5 clk = ~clk;

  // Count completion events and stamp the last one
  always @(posedge clk)
  begin
    if (crc_done_pulse === 1'b1)
    begin
      n_done <= n_done + 1;
      t_done <= $time;
    end
  end

  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One shift step; tap bit 0 is never a feedback point of its own
  function automatic int step(int sr, int b);
    int fb;
    fb = b ^ ((sr >> plen) & 1);
    sr = (sr << 1) | fb;
    if (fb == 1)
      sr = sr ^ (taps & 16'hFFFE);
    return sr & ((1 << (plen + 1)) - 1);
  endfunction : step

  // Shift every queued element, top used bit first
  task automatic model_drain();
    int e;
    while (q.size() > 0)
    begin
      e = q.pop_front();
      for (int i = plen; i >= 0; i--)
        exp_sr = step(exp_sr, (e >> i) & 1);
    end
  endtask : model_drain

  // Expected status word from the model queue
  function automatic logic [15:0] ctrl_exp(int go);
    int dp;
    dp = (plen > 7) ? 8 : 16;
    return {3'h0, 5'(q.size()), q.size() == dp, q.size() == 0, 1'b0, 1'(go), 4'(plen)};
  endfunction : ctrl_exp

  // Word write; byte mode queues the low byte before the high byte
  task automatic push_w(int v);
    cpu.push(2'b11, 16'(v), 1'b0);
    if (plen > 7)
      q.push_back(v & 16'hFFFF);
    else
    begin
      q.push_back(v & 16'h00FF);
      q.push_back((v >> 8) & 16'h00FF);
    end
  endtask : push_w

  // Taps, length and a known shift preload
  task automatic cfg(int p, int t);
    plen   = p;
    taps   = t;
    exp_sr = 16'h5A5A & ((1 << (p + 1)) - 1);
    cpu.wr(`CRC_REG_TAP, 2'b11, 16'(t));
    cpu.load_shift(16'(p), 16'(exp_sr));
  endtask : cfg

  // Start, optionally clear go and feed more mid-run, then check the result
  task automatic run_go(bit mid);
    int n0;
    int ne;
    n0 = n_done;
    ne = q.size() + mid;
    cpu.wr(`CRC_REG_CTRL, 2'b11, 16'(plen) | 16'h0010);
    t_go = $time;
    if (mid)
    begin
      cpu.wr(`CRC_REG_CTRL, 2'b11, 16'(plen));
      push_w($urandom);
    end
    for (int k = 0; k < 3000 && n_done == n0; k++)
      @(posedge clk);
    #1;
    chk(16'(n_done - n0), 16'h0001, "done pulses");
    // Go is taken at t_go, steps begin two edges later, the pulse shows one edge after the last
    chk(16'(t_done - t_go), 16'(10 * (ne * (plen + 1) + 2)), "shift time");
    model_drain();
    cpu.rd(`CRC_REG_SHIFT, rv);
    chk(rv, 16'(exp_sr), "crc result");
    cpu.rd(`CRC_REG_CTRL, rv);
    chk(rv, ctrl_exp(!mid), "drained status");
    cpu.wr(`CRC_REG_CTRL, 2'b11, 16'(plen));
  endtask : run_go

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h37FA));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and the tap register
    cpu.rd(`CRC_REG_CTRL, rv);
    chk(rv, `CRC_CTRL_RST, "ctrl reset");
    cpu.rd(`CRC_REG_SHIFT, rv);
    chk(rv, `CRC_SHIFT_RST, "shift reset");
    cpu.rd(`CRC_REG_TAP, rv);
    chk(rv, `CRC_TAP_RST, "tap reset");
    cpu.wr(`CRC_REG_TAP, 2'b11, 16'hFFFF);
    cpu.rd(`CRC_REG_TAP, rv);
    chk(rv, 16'hFFFE, "tap bit 0");
    @(posedge clk);
    clk_en <= 1'b0;
    cpu.wr(`CRC_REG_TAP, 2'b11, 16'h0000);
    clk_en <= 1'b1;
    cpu.rd(`CRC_REG_TAP, rv);
    chk(rv, 16'hFFFE, "tap frozen by enable");
    cpu.wr(`CRC_REG_FIFO, 2'b11, 16'h0000);
    cpu.rd(`CRC_REG_FIFO, rv);
    chk(rv, 16'h0000, "fifo read");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    $display("test reset_regs done");
    // Word mode: taps ending in 1 and 0, then a 12-bit length
    for (int i = 0; i < 3; i++)
    begin
      cfg((i == 2) ? 11 : 15, (i == 2) ? int'($urandom & 32'hFFFF) : 'h1021 - i);
      for (int j = 0; j < 3; j++)
        push_w($urandom);
      push_w(0);
      cpu.rd(`CRC_REG_CTRL, rv);
      chk(rv, ctrl_exp(0), "primed status");
      repeat (30) @(posedge clk);
      cpu.rd(`CRC_REG_SHIFT, rv);
      chk(rv, 16'(exp_sr), "no shift without go");
      run_go(1'b1);
    end
    $display("test word_mode done");
    // Byte mode: fill to full, overflow, then drain the survivor
    cfg(5, $urandom & 32'hFFFF);
    for (int j = 0; j < 6; j++)
      push_w($urandom);
    for (int j = 0; j < 4; j++)
    begin
      d = $urandom;
      cpu.push(j[0] ? 2'b10 : 2'b01, 16'(d), 1'b0);
      q.push_back(j[0] ? (d >> 8) & 'hFF : d & 'hFF);
    end
    cpu.rd(`CRC_REG_CTRL, rv);
    chk(rv, ctrl_exp(0), "byte full");
    d = $urandom & 'hFF;
    cpu.push(2'b01, 16'(d), 1'b1);
    q.delete();
    q.push_back(d);
    cpu.rd(`CRC_REG_CTRL, rv);
    chk(rv, ctrl_exp(0), "overflow wrap");
    run_go(1'b0);
    $display("test byte_mode done");
    // Word mode built from two lane writes
    cfg(9, $urandom & 32'hFFFF);
    d = $urandom & 'hFFFF;
    cpu.push(2'b01, 16'(d), 1'b0);
    cpu.rd(`CRC_REG_CTRL, rv);
    chk(rv, ctrl_exp(0), "half pair");
    cpu.push(2'b10, 16'(d), 1'b0);
    q.push_back(d);
    cpu.rd(`CRC_REG_CTRL, rv);
    chk(rv, ctrl_exp(0), "full pair");
    run_go(1'b0);
    $display("test byte_pairs done");
    tally_and_finish();
  end
endmodule : crc_engine_tb_top
